// >>> dam_alarm_unit.sv
// Dual alarm monitor: two limit/slope comparators, their registers and the
// hardware alarm indicator on one of the two shared I/O lines.
// Assumes sample_i pulses once per output update, all inputs on clk_i.
//
// Contract
// - Two monitors, own limit/span, shared control
// - Control register enables and selects source
// - Each monitor fixed-limit or slope mode
// - Control maps alarm to I/O line
// - Indicator asserts when either alarm active
// - Pin priority: misc, then alarm, then gpio
// - Limit bit 15 picks above or below
// - Limit in bits 13:0, bit 14 unused
// - Limit uses the monitored output's format
// - Fixed mode compares instantaneous value each sample
// - Slope mode compares change averaged over span
// - Evaluation uses unaveraged instantaneous samples
// - Indicator never latches, follows condition
// - Limit reads zero after power-up
// - Both monitors may watch same variable
// - Source field codes; zero disables alarm
// - Bits 11 and 15 enable slope mode
// - Control bits 2:0 enable, polarity, line
// - Span register holds eight-bit sample count
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module dam_monitor
	import dam_pkg::*;
(
	input wire logic clk_i, // Core clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic ce_i, // Clock enable
	input wire logic sample_i, // New output sample pulse
	input wire logic [2:0] src_i, // Source select, zero disables
	input wire logic slope_i, // Slope mode
	input wire logic above_i, // Alarm above limit
	input wire logic signed_i, // Source is twos complement
	input wire logic [13:0] value_i, // Selected instantaneous value
	input wire logic [13:0] limit_i, // Limit value, in the source's format
	input wire logic [7:0] span_i, // Slope sample count
	output logic active_o // Alarm condition
);

	logic active_q, active_d, primed_q, primed_d;
	logic signed [14:0] start_q, start_d, v_ext, l_ext;
	logic [7:0] cnt_q, cnt_d, cnt_n, span_eff;
	logic signed [15:0] delta;
	logic signed [23:0] delta_ext, lim_scaled;
	logic fixed_hit, slope_hit;

	// Limit and value share the source's number format
	assign v_ext = signed_i ? {value_i[13], value_i} : {1'b0, value_i};
	assign l_ext = signed_i ? {limit_i[13], limit_i} : {1'b0, limit_i};
	assign span_eff = (span_i == 8'h00) ? SPAN_MIN : span_i;
	assign cnt_n = 8'(cnt_q + 8'h01);
	assign delta = {v_ext[14], v_ext} - {start_q[14], start_q};
	assign delta_ext = {{8{delta[15]}}, delta};
	// Averaged change vs limit, scaled by span to avoid a divider
	assign lim_scaled = l_ext * $signed({1'b0, span_eff});
	assign fixed_hit = above_i ? (v_ext > l_ext) : (v_ext < l_ext);
	assign slope_hit = above_i ? (delta_ext > lim_scaled) : (delta_ext < lim_scaled);

	always_comb begin
		active_d = active_q;
		primed_d = primed_q;
		start_d = start_q;
		cnt_d = cnt_q;
		if (src_i == SRC_OFF) begin
			active_d = 1'b0;
			primed_d = 1'b0;
			cnt_d = 8'h00;
		end else if (sample_i) begin
			if (!slope_i) begin
				active_d = fixed_hit;
				primed_d = 1'b1;
				start_d = v_ext;
				cnt_d = 8'h00;
			end else if (!primed_q) begin
				primed_d = 1'b1;
				start_d = v_ext;
				cnt_d = 8'h00;
			end else if (cnt_n >= span_eff) begin
				active_d = slope_hit;
				start_d = v_ext;
				cnt_d = 8'h00;
			end else begin
				cnt_d = cnt_n;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			active_q <= 1'b0;
			primed_q <= 1'b0;
			start_q <= '0;
			cnt_q <= 8'h00;
		end else if (ce_i) begin
			active_q <= active_d;
			primed_q <= primed_d;
			start_q <= start_d;
			cnt_q <= cnt_d;
		end
	end

	assign active_o = active_q;

	off_clears_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && src_i == SRC_OFF |=> !active_q)
		else $error("disabled alarm still active");
	fixed_cmp_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && sample_i && src_i != SRC_OFF && !slope_i
		|=> active_q == $past(above_i ? (v_ext > l_ext) : (v_ext < l_ext)))
		else $error("fixed comparison wrong");
	hold_between_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!ce_i || (!sample_i && src_i != SRC_OFF)) |=> $stable(active_q))
		else $error("alarm changed without sample");
	slope_window_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && sample_i && slope_i && src_i != SRC_OFF && primed_q
		&& cnt_n >= span_eff |=> cnt_q == 8'h00)
		else $error("slope window did not restart");

endmodule : dam_monitor

////////////////////////////////////////////////////////////////////////////////
module dam_alarm_unit
	import dam_pkg::*;
(
	input wire logic clk_i, // Core clock, 200 MHz
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic ce_i, // Clock enable, freezes all state
	input wire logic reg_wr_i, // Register write strobe
	input wire logic [5:0] reg_addr_i, // Register byte address
	input wire logic [15:0] reg_wdata_i, // Register write data
	output logic [15:0] reg_rdata_o, // Register read data
	input wire logic sample_i, // Output variables updated
	input wire logic [13:0] supply_i, // Supply output
	input wire logic [13:0] accel_x_i, // X acceleration output
	input wire logic [13:0] accel_y_i, // Y acceleration output
	input wire logic [13:0] aux_adc_i, // Auxiliary converter output
	input wire logic [13:0] temp_i, // Temperature output
	input wire logic [13:0] tilt_x_i, // X inclination output
	input wire logic [13:0] tilt_y_result_i, // Y inclination output
	input wire logic [1:0] misc_owns_io_i, // Misc control claims line
	input wire logic [1:0] misc_out_i, // Misc control line level
	input wire logic [1:0] misc_oe_i, // Misc control line enable
	input wire logic [1:0] gpio_out_i, // I/O control line level
	input wire logic [1:0] gpio_oe_i, // I/O control line enable
	output logic io_line_zero_out_o, // Line zero level
	output logic io_line_zero_oe_o, // Line zero enable
	output logic io_line_one_out_o, // Line one level
	output logic io_line_one_oe_o, // Line one enable
	output logic [1:0] alarm_status_o // Alarm two, alarm one
);

	logic [15:0] lim1_q, lim1_d, lim2_q, lim2_d, span1_q, span1_d, span2_q, span2_d;
	logic [15:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
	logic [1:0] io_out_q, io_out_d, io_oe_q, io_oe_d;
	logic [13:0] src_val [8];
	logic [2:0] src1, src2;
	logic [1:0] active;
	logic wr, any_alarm, hw_en, hw_level;

	////////////////////////////////////////////////////////////////////////////
	// Registers

	assign wr = ce_i && reg_wr_i && !reg_addr_i[0];

	always_comb begin
		lim1_d = lim1_q;
		lim2_d = lim2_q;
		span1_d = span1_q;
		span2_d = span2_q;
		ctrl_d = ctrl_q;
		if (wr) begin
			unique case (reg_addr_i)
				OFF_ALARM_ONE_LIMIT: lim1_d = reg_wdata_i & MASK_LIMIT;
				OFF_ALARM_TWO_LIMIT: lim2_d = reg_wdata_i & MASK_LIMIT;
				OFF_ALARM_ONE_SPAN: span1_d = reg_wdata_i & MASK_SPAN;
				OFF_ALARM_TWO_SPAN: span2_d = reg_wdata_i & MASK_SPAN;
				OFF_ALARM_CONTROL: ctrl_d = reg_wdata_i & MASK_CONTROL;
				default: ;
			endcase
		end
		rdata_d = 16'h0000;
		if (!reg_addr_i[0]) begin
			unique case (reg_addr_i)
				OFF_ALARM_ONE_LIMIT: rdata_d = lim1_q;
				OFF_ALARM_TWO_LIMIT: rdata_d = lim2_q;
				OFF_ALARM_ONE_SPAN: rdata_d = span1_q;
				OFF_ALARM_TWO_SPAN: rdata_d = span2_q;
				OFF_ALARM_CONTROL: rdata_d = ctrl_q;
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			lim1_q <= RST_LIMIT;
			lim2_q <= RST_LIMIT;
			span1_q <= RST_SPAN;
			span2_q <= RST_SPAN;
			ctrl_q <= RST_CONTROL;
			rdata_q <= 16'h0000;
		end else if (ce_i) begin
			lim1_q <= lim1_d;
			lim2_q <= lim2_d;
			span1_q <= span1_d;
			span2_q <= span2_d;
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Monitors: raw instantaneous outputs, never averaged ones

	assign src_val[0] = 14'h0000;
	assign src_val[1] = supply_i;
	assign src_val[2] = accel_x_i;
	assign src_val[3] = accel_y_i;
	assign src_val[4] = aux_adc_i;
	assign src_val[5] = temp_i;
	assign src_val[6] = tilt_x_i;
	assign src_val[7] = tilt_y_result_i;
	assign src1 = ctrl_q[CTRL_SRC_ONE_LSB +: 3];
	assign src2 = ctrl_q[CTRL_SRC_TWO_LSB +: 3];

	// Each monitor picks its source independently, so both may share one
	dam_monitor u_alarm_one (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.sample_i(sample_i),
		.src_i(src1),
		.slope_i(ctrl_q[CTRL_SLOPE_ONE_BIT]),
		.above_i(lim1_q[LIMIT_ABOVE_BIT]),
		.signed_i(SRC_SIGNED[src1]),
		.value_i(src_val[src1]),
		.limit_i(lim1_q[LIMIT_MSB:0]),
		.span_i(span1_q[SPAN_MSB:0]),
		.active_o(active[0])
	);

	dam_monitor u_alarm_two (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.sample_i(sample_i),
		.src_i(src2),
		.slope_i(ctrl_q[CTRL_SLOPE_TWO_BIT]),
		.above_i(lim2_q[LIMIT_ABOVE_BIT]),
		.signed_i(SRC_SIGNED[src2]),
		.value_i(src_val[src2]),
		.limit_i(lim2_q[LIMIT_MSB:0]),
		.span_i(span2_q[SPAN_MSB:0]),
		.active_o(active[1])
	);

	////////////////////////////////////////////////////////////////////////////
	// I/O lines

	assign any_alarm = active[0] | active[1];
	assign hw_en = ctrl_q[CTRL_HW_EN_BIT];
	assign hw_level = ctrl_q[CTRL_HW_POL_BIT] ~^ any_alarm;

	always_comb begin
		for (int k = 0; k < 2; k++) begin
			if (misc_owns_io_i[k]) begin
				io_out_d[k] = misc_out_i[k];
				io_oe_d[k] = misc_oe_i[k];
			end else if (hw_en && ctrl_q[CTRL_HW_LINE_BIT] == k[0]) begin
				io_out_d[k] = hw_level;
				io_oe_d[k] = 1'b1;
			end else begin
				io_out_d[k] = gpio_out_i[k];
				io_oe_d[k] = gpio_oe_i[k];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			io_out_q <= 2'h0;
			io_oe_q <= 2'h0;
		end else if (ce_i) begin
			io_out_q <= io_out_d;
			io_oe_q <= io_oe_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign io_line_zero_out_o = io_out_q[0];
	assign io_line_zero_oe_o = io_oe_q[0];
	assign io_line_one_out_o = io_out_q[1];
	assign io_line_one_oe_o = io_oe_q[1];
	assign alarm_status_o = active;

	limit_reset_a: assert property (@(posedge clk_i)
		$rose(rst_n_i) |-> lim1_q == RST_LIMIT && lim2_q == RST_LIMIT)
		else $error("limit not zero after reset");
	limit_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr && reg_addr_i == OFF_ALARM_TWO_LIMIT
		|=> lim2_q == ($past(reg_wdata_i) & MASK_LIMIT) && !lim2_q[14])
		else $error("limit write lost");
	hw_line_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && hw_en && !ctrl_q[CTRL_HW_LINE_BIT] && !misc_owns_io_i[0]
		|=> io_oe_q[0] && io_out_q[0] == $past(ctrl_q[1] ~^ (active[0] | active[1])))
		else $error("alarm indicator wrong");
	misc_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && misc_owns_io_i[1]
		|=> io_out_q[1] == $past(misc_out_i[1]) && io_oe_q[1] == $past(misc_oe_i[1]))
		else $error("misc control lost line");
	gpio_last_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !misc_owns_io_i[1] && !(hw_en && ctrl_q[CTRL_HW_LINE_BIT])
		|=> io_out_q[1] == $past(gpio_out_i[1]) && io_oe_q[1] == $past(gpio_oe_i[1]))
		else $error("gpio control lost line");
	ce_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!ce_i |=> $stable(ctrl_q) && $stable(io_out_q))
		else $error("state moved while disabled");

endmodule : dam_alarm_unit

// >>> dam_host.sv
// Host model for the dual alarm monitor: register writes and reads on the
// unit's own port, standing in for what the serial link hands over.
// Assumes the bench clock; drives only just after rising edges.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module dam_host (
	input wire logic clk_i, // Core clock
	output logic reg_wr_o, // Write strobe
	output logic [5:0] reg_addr_o, // Byte address
	output logic [15:0] reg_wdata_o, // Write data
	input wire logic [15:0] reg_rdata_i // Read data
);
	initial begin
		reg_wr_o = 1'b0;
		reg_addr_o = 6'h00;
		reg_wdata_o = 16'h0000;
	end

	// Whole word per strobe; limits are written in the source's format
	task write_reg(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_wr_o <= 1'b1;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		// Released data must not keep showing the last word
		reg_wdata_o <= ~d;
	endtask : write_reg

	task read_reg(input logic [5:0] a, output logic [15:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		@(posedge clk_i);
		#1;
		d = reg_rdata_i;
	endtask : read_reg
endmodule : dam_host

// >>> dam_pkg.sv
// Package for the dual alarm monitor: register offsets, field positions,
// reset values and source codes.
// Assumes a 16-bit register port with byte addresses, words on even addresses.
package dam_pkg;

	localparam logic [5:0] OFF_ALARM_ONE_LIMIT = 6'h20;
	localparam logic [5:0] OFF_ALARM_TWO_LIMIT = 6'h22;
	localparam logic [5:0] OFF_ALARM_ONE_SPAN = 6'h24;
	localparam logic [5:0] OFF_ALARM_TWO_SPAN = 6'h26;
	localparam logic [5:0] OFF_ALARM_CONTROL = 6'h28;

	localparam logic [15:0] RST_LIMIT = 16'h0000;
	localparam logic [15:0] RST_SPAN = 16'h0000;
	localparam logic [15:0] RST_CONTROL = 16'h0000;

	// Bits that read back; unused bits read as zero
	localparam logic [15:0] MASK_LIMIT = 16'hBFFF;
	localparam logic [15:0] MASK_SPAN = 16'h00FF;
	localparam logic [15:0] MASK_CONTROL = 16'hFF07;

	localparam int LIMIT_ABOVE_BIT = 15;
	localparam int LIMIT_MSB = 13;
	localparam int SPAN_MSB = 7;
	localparam int CTRL_SLOPE_TWO_BIT = 15;
	localparam int CTRL_SRC_TWO_LSB = 12;
	localparam int CTRL_SLOPE_ONE_BIT = 11;
	localparam int CTRL_SRC_ONE_LSB = 8;
	localparam int CTRL_HW_EN_BIT = 2;
	localparam int CTRL_HW_POL_BIT = 1;
	localparam int CTRL_HW_LINE_BIT = 0;

	typedef enum logic [2:0] {
		SRC_OFF = 3'b000,
		SRC_SUPPLY = 3'b001,
		SRC_ACCEL_X = 3'b010,
		SRC_ACCEL_Y = 3'b011,
		SRC_AUX_ADC = 3'b100,
		SRC_TEMP = 3'b101,
		SRC_TILT_X = 3'b110,
		SRC_TILT_Y = 3'b111
	} dam_src_type;

	// One bit per source code: 1 = twos complement, 0 = straight binary
	localparam logic [7:0] SRC_SIGNED = 8'hCC;

	localparam logic [7:0] SPAN_MIN = 8'h01;

endpackage : dam_pkg

// >>> tb_dam_alarm_unit.sv
// Self-checking bench for the dual alarm monitor unit.
// Assumes the host model drives the register port; bench drives samples and pins.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module tb_dam_alarm_unit;
	import dam_pkg::*;
	logic clk_i, rst_n_i, ce_i, sample_i, reg_wr;
	logic [5:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd;
	logic [13:0] vin [8];
	logic [1:0] misc_owns, misc_out, misc_oe, gpio_out, gpio_oe, status, eo, ee;
	logic l0_out, l0_oe, l1_out, l1_oe;
	int comparisons = 0;
	int fail_count = 0;
	logic [5:0] offs [6] = '{OFF_ALARM_ONE_LIMIT, OFF_ALARM_TWO_LIMIT, OFF_ALARM_ONE_SPAN,
		OFF_ALARM_TWO_SPAN, OFF_ALARM_CONTROL, 6'h2A};
	logic [15:0] msk [6] = '{MASK_LIMIT, MASK_LIMIT, MASK_SPAN, MASK_SPAN, MASK_CONTROL, 16'h0000};
	logic [13:0] wv [4] = '{14'h0078, 14'h0046, 14'h0014, 14'h0064};
	logic [1:0] ws [4] = '{2'b01, 2'b00, 2'b10, 2'b00};
	logic [13:0] sv [9] = '{14'h0000, 14'h000A, 14'h0014, 14'h001E, 14'h002C, 14'h0032,
		14'h003C, 14'h0046, 14'h0050};
	logic ss [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

	dam_host dam_host_i (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

	dam_alarm_unit dam_alarm_unit_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_rdata_o(reg_rdata), .sample_i(sample_i), .supply_i(vin[1]), .accel_x_i(vin[2]),
		.accel_y_i(vin[3]), .aux_adc_i(vin[4]), .temp_i(vin[5]), .tilt_x_i(vin[6]),
		.tilt_y_result_i(vin[7]), .misc_owns_io_i(misc_owns), .misc_out_i(misc_out),
		.misc_oe_i(misc_oe), .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe),
		.io_line_zero_out_o(l0_out), .io_line_zero_oe_o(l0_oe), .io_line_one_out_o(l1_out),
		.io_line_one_oe_o(l1_oe), .alarm_status_o(status));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out

	task check_reg(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: register read %h, expected %h", $time, got, exp);
		end
	endtask : check_reg

	task check_status(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: alarm status %b, expected %b", $time, got, exp);
		end
	endtask : check_status

	task check_line(input logic [3:0] got, input logic [3:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: lines oe/out %b, expected %b", $time, got, exp);
		end
	endtask : check_line

	// One sample pulse with only the chosen source non-zero, then let it settle
	task smp(input int c, input logic [13:0] v);
		@(posedge clk_i);
		for (int i = 1; i < 8; i++) vin[i] <= (i == c) ? v : 14'h0000;
		sample_i <= 1'b1;
		@(posedge clk_i);
		sample_i <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask : smp

	initial begin
		#50000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		sample_i = 1'b0;
		misc_owns = 2'b00;
		misc_out = 2'b00;
		misc_oe = 2'b00;
		gpio_out = 2'b10;
		gpio_oe = 2'b01;
		for (int i = 0; i < 8; i++) vin[i] = 14'h0000;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Reset values, odd and unmapped addresses
		foreach (offs[i]) begin
			dam_host_i.read_reg(offs[i], rd);
			check_reg(rd, 16'h0000);
		end
		dam_host_i.write_reg(6'h21, 16'hFFFF);
		dam_host_i.read_reg(OFF_ALARM_ONE_LIMIT, rd);
		check_reg(rd, 16'h0000);
		foreach (offs[i]) begin
			dam_host_i.write_reg(offs[i], 16'hFFFF);
			dam_host_i.read_reg(offs[i], rd);
			check_reg(rd, msk[i]);
			dam_host_i.write_reg(offs[i], 16'h0000);
		end
		// Every non-zero source code, above and below, signed and straight binary
		for (int c = 1; c < 8; c++) begin
			dam_host_i.write_reg(OFF_ALARM_CONTROL, 16'(c << 8));
			dam_host_i.write_reg(OFF_ALARM_ONE_LIMIT, 16'h8010);
			smp(c, 14'h0100);
			check_status(status, 2'b01);
			dam_host_i.write_reg(OFF_ALARM_ONE_LIMIT, 16'hBFF0);
			smp(c, 14'h0000);
			check_status(status, {1'b0, SRC_SIGNED[c]});
			dam_host_i.write_reg(OFF_ALARM_ONE_LIMIT, 16'h0010);
			smp(c, 14'h0005);
			check_status(status, 2'b01);
		end
		// Temperature output falls as heat rises: a hot alarm uses the below select
		dam_host_i.write_reg(OFF_ALARM_CONTROL, 16'h0500);
		dam_host_i.write_reg(OFF_ALARM_ONE_LIMIT, 16'h0100);
		smp(5, 14'h0110);
		check_status(status, 2'b00);
		smp(5, 14'h00F0);
		check_status(status, 2'b01);
		dam_host_i.write_reg(OFF_ALARM_CONTROL, 16'h0000);
		@(posedge clk_i);
		#1;
		check_status(status, 2'b00);
		// Window: both monitors on one source, opposite directions, strict compare
		dam_host_i.write_reg(OFF_ALARM_ONE_LIMIT, 16'h8064);
		dam_host_i.write_reg(OFF_ALARM_TWO_LIMIT, 16'h0032);
		dam_host_i.write_reg(OFF_ALARM_CONTROL, 16'h2200);
		foreach (wv[k]) begin
			smp(2, wv[k]);
			check_status(status, ws[k]);
		end
		// Indicator on each line and polarity, follows either alarm
		for (int ln = 0; ln < 2; ln++) begin
			for (int p = 0; p < 2; p++) begin
				dam_host_i.write_reg(OFF_ALARM_CONTROL, 16'h2204 | 16'(p << 1) | 16'(ln));
				for (int k = 0; k < 3; k++) begin
					smp(2, wv[k]);
					@(posedge clk_i);
					#1;
					eo = gpio_out;
					eo[ln] = (ws[k] != 2'b00) ? p[0] : ~p[0];
					ee = gpio_oe;
					ee[ln] = 1'b1;
					check_line({l1_oe, l0_oe, l1_out, l0_out}, {ee, eo});
				end
			end
		end
		// Priority: misc over alarm, gpio when indicator off
		@(posedge clk_i);
		misc_owns <= 2'b11;
		misc_out <= 2'b01;
		misc_oe <= 2'b10;
		repeat (3) @(posedge clk_i);
		#1;
		check_line({l1_oe, l0_oe, l1_out, l0_out}, 4'b1001);
		@(posedge clk_i);
		misc_owns <= 2'b00;
		dam_host_i.write_reg(OFF_ALARM_CONTROL, 16'h2203);
		repeat (2) @(posedge clk_i);
		#1;
		check_line({l1_oe, l0_oe, l1_out, l0_out}, {gpio_oe, gpio_out});
		// Slope mode, span of four samples, two windows
		dam_host_i.write_reg(OFF_ALARM_CONTROL, 16'h0000);
		dam_host_i.write_reg(OFF_ALARM_ONE_LIMIT, 16'h800A);
		dam_host_i.write_reg(OFF_ALARM_ONE_SPAN, 16'h0004);
		dam_host_i.write_reg(OFF_ALARM_CONTROL, 16'h0A00);
		foreach (sv[k]) begin
			smp(2, sv[k]);
			check_status(status, {1'b0, ss[k]});
		end
		// Clock enable low: writes and samples are both frozen out
		@(posedge clk_i);
		ce_i <= 1'b0;
		dam_host_i.write_reg(OFF_ALARM_CONTROL, 16'h0000);
		for (int k = 0; k < 4; k++) smp(2, 14'h1000);
		check_status(status, 2'b00);
		@(posedge clk_i);
		ce_i <= 1'b1;
		dam_host_i.read_reg(OFF_ALARM_CONTROL, rd);
		check_reg(rd, 16'h0A00);
		for (int k = 0; k < 4; k++) smp(2, 14'h1000);
		check_status(status, 2'b01);
		// Reset in mid-run clears limits and alarm state
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		dam_host_i.read_reg(OFF_ALARM_ONE_LIMIT, rd);
		check_reg(rd, 16'h0000);
		check_status(status, 2'b00);
		close_out();
	end
endmodule : tb_dam_alarm_unit
